/* File: rtl/rbs_consts.vh */
// Purpose: Constants for the reset and boot start sequencer
// Assumes: 100 MHz aclk, AXI4-Lite register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
`ifndef RBS_CONSTS_VH
`define RBS_CONSTS_VH
`define RBS_REG_CTRL        4'h0
`define RBS_REG_STATUS      4'h4
`define RBS_REG_WAIT        4'h8
`define RBS_REG_BOOTLEN     4'hc
`define RBS_ADDR_W          14
`define RBS_DATA_W          24
`define RBS_START_ADDR      14'h0000
`define RBS_BOOT_WAIT_RST   3'h3
`define RBS_PM_WAIT_RST     3'h7
`define RBS_BOOT_PAGE_RST   3'h0
`define RBS_BOOTLEN_RST     13'h0060
`define RBS_PLL_LOCK_CYC    2000
`define RBS_CTRL_GO_BIT     0
`define RBS_CTRL_FORCE_BIT  1
`define RBS_ST_IDLE         3'h0
`define RBS_ST_DECIDE       3'h1
`define RBS_ST_BADDR        3'h2
`define RBS_ST_BWAIT        3'h3
`define RBS_ST_GRANT        3'h4
`define RBS_ST_RUN          3'h5
`define RBS_RESP_OKAY       2'h0
`define RBS_RESP_SLVERR     2'h2
`endif

/* File: rtl/rbs_sequencer.v */
// Purpose: Reset and boot start sequencer of a fixed-point DSP core
// Assumes: Single clock aclk; straps and pins pass two flip-flops
// Notes:   Boot reads bytes on data[15:8]; upper two page bits drive data[23:22], page bit 0 drives addr_out[13]
// Contract
// R1 - Reset returns entire block to initial state; reset_n leaves AXI channels and synchronisers as they are
// R2 - Reset source holds reset 2000 input cycles
// R3 - Later resets keep clock running, no delay
// R4 - Reset empties stacks, masks interrupts, clears mode
// R5 - Boot only without bus request and map zero; a software forced boot ignores both
// R6 - First fetch from internal address zero
// R7 - One shared 14-bit address output bus
// R8 - 24-bit data bus, input only during boot
// R9 - Top two data bits carry boot address
// R10 - Boot source select: zero EPROM, one host
// R11 - Sample memory map select for layout
// R12 - Automatic boot loads from page zero
// R13 - Boot wait states reset to three
// R14 - Program wait states reset to seven
// R15 - Bus grant waits for current boot byte
// R16 - Synchronise reset before releasing sequencing
`timescale 1ns/1ps
`include "rbs_consts.vh"
module rbs_sequencer
(
  // Clock and bus reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Processor reset pin and straps
  input  wire        reset_n,
  input  wire        memory_map_select,
  input  wire        boot_source_select,
  input  wire        ext_bus_request_n,
  // Memory bus
  output reg  [13:0] addr_out,
  input  wire [23:0] data_in,
  output reg  [23:0] data_out,
  output reg  [23:0] data_oe,
  output reg         boot_memory_select_n,
  output reg         program_memory_select_n,
  output reg         data_memory_select_n,
  output reg         rd_n,
  output reg         ext_bus_grant_n,
  // Core control
  output reg         core_reset,
  output reg         stacks_empty,
  output reg  [9:0]  interrupt_mask_register,
  output reg  [6:0]  mode_status_register,
  output reg         host_boot_req,
  output reg         boot_byte_valid,
  output reg  [7:0]  boot_byte,
  output reg         fetch_start,
  output reg  [13:0] fetch_addr,
  output reg         map_layout
);

  // Reset pin and strap synchronisers
  reg [1:0] rst_sync;
  reg [1:0] memory_map_select_sync;
  reg [1:0] bsel_sync;
  reg [1:0] br_sync;
  always @(posedge aclk)
  begin
    rst_sync  <= {rst_sync[0], reset_n};     // R16
    memory_map_select_sync <= {memory_map_select_sync[0], memory_map_select};
    bsel_sync <= {bsel_sync[0], boot_source_select};
    br_sync   <= {br_sync[0], ext_bus_request_n};
  end
  wire rst_n_s = rst_sync[1];
  wire br_n_s  = br_sync[1];
  wire seq_rst = ~aresetn | ~rst_n_s;        // R1

  // Software registers and sequencer state
  reg        go_mode;
  reg        force_boot;
  reg [2:0]  boot_page;
  reg [2:0]  boot_wait;
  reg [2:0]  pm_wait;
  reg [12:0] boot_len;
  reg [2:0]  state;
  reg [12:0] byte_cnt;
  reg [2:0]  wait_cnt;

  // AXI write channel: addr and data taken in either order
  reg        aw_held;
  reg        w_held;
  reg [3:0]  aw_addr;
  reg [31:0] w_data;
  reg        w_strb0;
  wire       do_write = aw_held & w_held & ~s_axi_bvalid;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h0;
      w_strb0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RBS_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_held & ~s_axi_awready;
      s_axi_wready  <= ~w_held & ~s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[3:2] == 2'h1) ? `RBS_RESP_SLVERR
                                               : `RBS_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; force bit self-clears when boot starts
  wire boot_start;
  always @(posedge aclk)
  begin
    if (!aresetn || !rst_n_s)
    begin
      go_mode    <= 1'b0;
      force_boot <= 1'b0;
      boot_page  <= `RBS_BOOT_PAGE_RST;     // R12
      boot_wait  <= `RBS_BOOT_WAIT_RST;     // R13
      pm_wait    <= `RBS_PM_WAIT_RST;       // R14
      boot_len   <= `RBS_BOOTLEN_RST;
    end
    else
    begin
      if (boot_start)
        force_boot <= 1'b0;
      if (do_write && aw_addr == `RBS_REG_CTRL && w_strb0)
      begin
        go_mode <= w_data[`RBS_CTRL_GO_BIT];
        if (w_data[`RBS_CTRL_FORCE_BIT])
          force_boot <= 1'b1;
        boot_page <= w_data[4:2];
      end
      if (do_write && aw_addr == `RBS_REG_WAIT && w_strb0)
      begin
        boot_wait <= w_data[2:0];
        pm_wait   <= w_data[6:4];
      end
      if (do_write && aw_addr == `RBS_REG_BOOTLEN)
        boot_len <= w_data[12:0];
    end
  end

  // AXI read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RBS_RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RBS_RESP_OKAY;
      case (s_axi_araddr)
        `RBS_REG_CTRL:    s_axi_rdata <= {27'h0, boot_page,
                                          force_boot, go_mode};
        `RBS_REG_STATUS:  s_axi_rdata <= {16'h0, byte_cnt, state};
        `RBS_REG_WAIT:    s_axi_rdata <= {25'h0, pm_wait, 1'b0,
                                          boot_wait};
        `RBS_REG_BOOTLEN: s_axi_rdata <= {19'h0, boot_len};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `RBS_RESP_SLVERR;
        end
      endcase
    end
    else
      s_axi_arready <= 1'b1;
  end

  // Boot decision: no request pending, map zero, or forced
  assign boot_start = (state == `RBS_ST_DECIDE &&
                       br_n_s && !memory_map_select_sync[1]) ||   // R5
                      (state == `RBS_ST_RUN && force_boot);
  wire [15:0] boot_addr = {boot_page, byte_cnt};

  // Sequencer; no settle delay after release, clock never gated
  always @(posedge aclk)
  begin
    if (seq_rst)                                     // R3
    begin
      state                   <= `RBS_ST_IDLE;
      byte_cnt                <= 13'h0;
      wait_cnt                <= 3'h0;
      core_reset              <= 1'b1;
      stacks_empty            <= 1'b1;               // R4
      interrupt_mask_register <= 10'h0;              // R4
      mode_status_register    <= 7'h0;               // R4
      addr_out                <= 14'h0;
      data_out                <= 24'h0;
      data_oe                 <= 24'h0;
      boot_memory_select_n    <= 1'b1;
      program_memory_select_n <= 1'b1;
      data_memory_select_n    <= 1'b1;
      rd_n                    <= 1'b1;
      ext_bus_grant_n         <= 1'b1;
      host_boot_req           <= 1'b0;
      boot_byte_valid         <= 1'b0;
      boot_byte               <= 8'h0;
      fetch_start             <= 1'b0;
      fetch_addr              <= 14'h0;
      map_layout              <= 1'b0;
    end
    else
    begin
      boot_byte_valid <= 1'b0;
      fetch_start     <= 1'b0;
      case (state)
        `RBS_ST_IDLE:
        begin
          map_layout <= memory_map_select_sync[1];                // R11
          state      <= `RBS_ST_DECIDE;
        end
        `RBS_ST_DECIDE:
        begin
          if (boot_start && bsel_sync[1])            // R10
          begin
            host_boot_req <= 1'b1;
            state         <= `RBS_ST_RUN;
          end
          else if (boot_start)
          begin
            byte_cnt <= 13'h0;
            state    <= `RBS_ST_BADDR;
          end
          else
            state <= `RBS_ST_RUN;
        end
        `RBS_ST_BADDR:
        begin
          addr_out             <= boot_addr[13:0];   // R7
          data_out             <= {boot_addr[15:14], 22'h0};
          data_oe              <= 24'hc00000;        // R9 R8
          boot_memory_select_n <= 1'b0;
          rd_n                 <= 1'b0;
          wait_cnt             <= boot_wait;
          state                <= `RBS_ST_BWAIT;
        end
        `RBS_ST_BWAIT:
        begin
          if (wait_cnt != 3'h0)
            wait_cnt <= wait_cnt - 3'h1;
          else
          begin
            boot_byte            <= data_in[15:8];
            boot_byte_valid      <= 1'b1;
            boot_memory_select_n <= 1'b1;
            rd_n                 <= 1'b1;
            data_oe              <= 24'h0;
            byte_cnt             <= byte_cnt + 13'h1;
            if (byte_cnt + 13'h1 == boot_len)
              state <= `RBS_ST_RUN;
            else if (!br_n_s)
              state <= `RBS_ST_GRANT;                // R15
            else
              state <= `RBS_ST_BADDR;
          end
        end
        `RBS_ST_GRANT:
        begin
          ext_bus_grant_n <= br_n_s;                 // R15
          if (br_n_s)
            state <= `RBS_ST_BADDR;
        end
        `RBS_ST_RUN:
        begin
          if (boot_start)
          begin
            byte_cnt   <= 13'h0;
            core_reset <= 1'b1;
            state      <= `RBS_ST_BADDR;
          end
          else if (core_reset)
          begin
            core_reset  <= 1'b0;
            fetch_start <= 1'b1;
            fetch_addr  <= `RBS_START_ADDR;          // R6
            stacks_empty <= 1'b0;
          end
          ext_bus_grant_n <= br_n_s | boot_start;    // R15
        end
        default:
          state <= `RBS_ST_IDLE;
      endcase
    end
  end

endmodule

/* File: verification/rbs_monitor.sv */
// Purpose: Port assertions for the sequencer
// Assumes: One clock, aresetn synchronous low
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module rbs_monitor
(
  // Clock and resets
  input logic        aclk,
  input logic        aresetn,
  input logic        reset_n,
  // Memory bus
  input logic [23:0] data_oe,
  input logic        boot_memory_select_n,
  input logic        rd_n,
  input logic        ext_bus_grant_n,
  // Core control
  input logic        core_reset,
  input logic        stacks_empty,
  input logic [9:0]  interrupt_mask_register,
  input logic [6:0]  mode_status_register,
  input logic        host_boot_req,
  input logic        boot_byte_valid,
  input logic        fetch_start,
  input logic [13:0] fetch_addr
);
  // One domain for every check
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_reset_clears:
    assert property ($fell(reset_n) |-> ##[1:4] (stacks_empty &&
      core_reset && interrupt_mask_register == 10'h000 &&
      mode_status_register == 7'h00)) else $error("reset state");
  chk_oe_boot_only:
    assert property (data_oe[21:0] == 22'h0 &&
      (data_oe == 24'h0 || !boot_memory_select_n)) else $error("oe");
  chk_page_drive:
    assert property (!boot_memory_select_n && !rd_n |->
      data_oe[23:22] == 2'b11) else $error("page bits");
  chk_fetch_zero:
    assert property (fetch_start |-> fetch_addr == 14'h0000 &&
      boot_memory_select_n) else $error("fetch addr");
  chk_grant_idle:
    assert property (!ext_bus_grant_n |-> boot_memory_select_n && rd_n)
      else $error("grant in boot");
  chk_host_noeprom:
    assert property (host_boot_req |-> boot_memory_select_n)
      else $error("host boot");
  chk_byte_spacing:
    assert property (boot_byte_valid |=> !boot_byte_valid [*4])
      else $error("byte spacing");
  chk_sync_release:
    assert property ($rose(reset_n) |-> (core_reset && !fetch_start) [*5])
      else $error("release sync");
endmodule

/* File: verification/rbs_boot_mem_model.sv */
// Purpose: Boot memory, reset generator and straps
// Assumes: Byte k of page zero holds k xor a5 on bits 15:8
// Notes: Undriven lines show the inverse of their last value
`timescale 1ns/1ps
module rbs_boot_mem_model
(
  // Clock and memory bus
  input  logic        aclk,
  input  logic [13:0] addr_out,
  input  logic [23:0] data_out,
  input  logic [23:0] data_oe,
  input  logic        boot_memory_select_n,
  input  logic        rd_n,
  output logic [23:0] data_in,
  // Reset pin and straps
  output logic        reset_n = 1'b0,
  output logic        memory_map_select = 1'b0,
  output logic        boot_source_select = 1'b0,
  output logic        ext_bus_request_n = 1'b1
);
  logic [23:0] drv = 24'h0;
  // Wire level from the sequencer's enables; the model drives every other line
  assign data_in = (data_oe & data_out) | (~data_oe & drv);
  // Memory answers one cycle after a select
  always @(posedge aclk)
    if (!boot_memory_select_n && !rd_n)
      drv <= {~drv[23:16], addr_out[7:0] ^ 8'ha5, ~drv[7:0]};
    else
      drv <= ~drv;
  // Reset pulse of n cycles with given straps
  task pulse(input int n, input logic m, s, q);
    begin
      reset_n <= 1'b0;
      memory_map_select <= m;
      boot_source_select <= s;
      ext_bus_request_n <= q;
      repeat (n) @(posedge aclk);
      reset_n <= 1'b1;
    end
  endtask
endmodule

/* File: verification/rbs_sequencer_test.sv */
// Purpose: Self-checking bench for the sequencer
// Assumes: 100 MHz aclk, register defaults
// Notes: Outputs are read as sampled at the rising edge
`timescale 1ns/1ps
`include "rbs_consts.vh"
module rbs_sequencer_test;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic reset_n, memory_map_select, boot_source_select, ext_bus_request_n;
  logic [13:0] addr_out, fetch_addr;
  logic [23:0] data_in, data_out, data_oe;
  logic boot_memory_select_n, program_memory_select_n, data_memory_select_n;
  logic rd_n, ext_bus_grant_n, core_reset, stacks_empty, host_boot_req;
  logic boot_byte_valid, fetch_start, map_layout;
  logic [9:0] interrupt_mask_register;
  logic [6:0] mode_status_register;
  logic [7:0] boot_byte;
  int fails = 0, n_compared = 0;
  rbs_sequencer dut_u (.*);
  rbs_boot_mem_model pm_u (.*);
  always #5 aclk = ~aclk;
  // Count and report one comparison
  task chk(input logic ok, input string m);
    begin
      n_compared++;
      if (ok !== 1'b1)
      begin
        fails++;
        $display("ERROR %0t %s", $time, m);
      end
    end
  endtask
  task stop_test;
    begin
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // AXI write, address and data offered together
  // Waits as long as the slave needs; only the watchdog ends a hang
  task wr(input [3:0] a, input [31:0] d, output [1:0] r);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [31:0] d);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
    end
  endtask
  // Reset pulse, then count boot bytes up to the first fetch
  task run(input int w, input logic m, s, q, output int nb);
    int n;
    begin
      pm_u.pulse(w, m, s, q);
      nb = 0;
      n = 0;
      while (fetch_start !== 1'b1 && n < 2000)
      begin
        @(posedge aclk);
        n++;
        if (boot_byte_valid === 1'b1)
        begin
          chk(boot_byte === (nb[7:0] ^ 8'ha5), "byte");
          nb++;
        end
      end
      chk(n < 2000 && fetch_addr === `RBS_START_ADDR, "fetch");
    end
  endtask
  task t_power;
    int nb;
    logic [31:0] d;
    begin
      run(2000, 1'b0, 1'b0, 1'b1, nb);
      chk(nb == `RBS_BOOTLEN_RST && map_layout === 1'b0, "boot");
      rd(`RBS_REG_WAIT, d);
      chk(d === 32'h00000073, "wait reset");
      chk(program_memory_select_n === 1'b1 &&
          data_memory_select_n === 1'b1, "selects");
      $display("t_power done");
    end
  endtask
  task t_regs;
    int nb;
    logic [31:0] d;
    logic [1:0] r;
    begin
      wr(`RBS_REG_WAIT, 32'h00000011, r);
      rd(`RBS_REG_WAIT, d);
      chk(d === 32'h00000011, "wait write");
      wr(`RBS_REG_STATUS, 32'h0, r);
      chk(r === `RBS_RESP_SLVERR, "status write");
      run(8, 1'b0, 1'b0, 1'b1, nb);
      rd(`RBS_REG_WAIT, d);
      chk(d === 32'h00000073 && nb == `RBS_BOOTLEN_RST, "pin reset");
      $display("t_regs done");
    end
  endtask
  // Software forced boot of four bytes from page five
  task t_force;
    int nb, n;
    logic [1:0] r;
    logic ok, good;
    begin
      wr(`RBS_REG_BOOTLEN, 32'h00000004, r);
      wr(`RBS_REG_CTRL, 32'h00000016, r);
      nb = 0;
      ok = 1'b0;
      good = 1'b1;
      for (n = 0; n < 200 && fetch_start !== 1'b1; n++)
      begin
        @(posedge aclk);
        if (boot_memory_select_n === 1'b0 && rd_n === 1'b0)
          ok = addr_out[13] === 1'b1 && data_out[23:22] === 2'b10;
        if (boot_byte_valid === 1'b1)
        begin
          good &= (boot_byte === (nb[7:0] ^ 8'ha5));
          nb++;
        end
      end
      chk(ok, "page bits");
      chk(good && nb == 4 && fetch_addr === `RBS_START_ADDR, "forced");
      $display("t_force done");
    end
  endtask
  task t_noboot;
    int nb;
    begin
      run(8, 1'b1, 1'b0, 1'b1, nb);
      chk(nb == 0 && map_layout === 1'b1, "map one");
      run(8, 1'b0, 1'b0, 1'b0, nb);
      chk(nb == 0, "request");
      $display("t_noboot done");
    end
  endtask
  task t_host;
    int n;
    begin
      pm_u.pulse(8, 1'b0, 1'b1, 1'b1);
      for (n = 0; n < 50 && host_boot_req !== 1'b1; n++)
        @(posedge aclk);
      chk(host_boot_req === 1'b1, "host");
      $display("t_host done");
    end
  endtask
  task t_grant;
    int n;
    logic seen;
    begin
      pm_u.pulse(8, 1'b0, 1'b0, 1'b1);
      for (n = 0; n < 50 && boot_memory_select_n !== 1'b0; n++)
        @(posedge aclk);
      pm_u.ext_bus_request_n <= 1'b0;
      seen = 1'b0;
      for (n = 0; n < 100 && ext_bus_grant_n !== 1'b0; n++)
      begin
        @(posedge aclk);
        seen |= (boot_byte_valid === 1'b1);
      end
      chk(seen && n < 100, "grant");
      pm_u.ext_bus_request_n <= 1'b1;
      $display("t_grant done");
    end
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_power;
    t_regs;
    t_force;
    t_noboot;
    t_host;
    t_grant;
    stop_test;
  end
  initial
  begin
    #300000;
    fails++;
    stop_test;
  end
endmodule
bind rbs_sequencer rbs_monitor mon_u (.*);
